// ### logic/rls_ctl.sv
// limit switch and regulator 1 control registers with sequencing outputs
`timescale 1ns/1ps
module rls_ctl
    import rls_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire rls_bus_s i_bus,
    output logic [15:0] o_rd_data,
    input wire logic i_sm_reload,
    input wire rls_pwr_e i_pwr_state,
    input wire logic i_slot_strobe,
    input wire logic [3:0] i_slot,
    input wire logic i_limit_det,
    input wire logic i_reg1_en,
    input wire logic i_other_regs_off,
    output logic o_switch_on,
    output logic o_bulk_detect_en,
    output logic o_sys_shutdown,
    output logic o_reg1_switch_mode,
    output logic [4:0] o_reg1_voltage_code,
    output logic [11:0] o_reg1_mv,
    output logic o_reg1_discharge,
    output logic o_irq
);
    rls_sw_ctl_s sw_r;
    rls_sw_ctl_s sw_nxt;
    rls_rg1_ctl_s rg1_r;
    rls_rg1_ctl_s rg1_nxt;
    logic [RLS_IRQ_W-1:0] stat_r;
    logic [RLS_IRQ_W-1:0] stat_nxt;
    logic [RLS_IRQ_W-1:0] mask_r;
    logic [RLS_IRQ_W-1:0] mask_nxt;
    logic [RLS_IRQ_W-1:0] ev;
    logic [15:0] rd_r;
    logic [15:0] rd_nxt;
    logic seq_on_r;
    logic seq_on_nxt;
    logic sw_out_r;
    logic sw_out_nxt;
    logic bulk_r;
    logic bulk_nxt;
    logic sysoff_r;
    logic sysoff_nxt;
    logic dis_r;
    logic dis_nxt;
    rls_pwr_e pwr_prev_r;
    logic enter_active;
    logic enter_off;
    logic up_slot_hit;
    logic down_slot_hit;
    logic fault_swoff;

    //--------------------------------------------------------------------------
    // sequencing decode
    //--------------------------------------------------------------------------
    assign enter_active = (i_pwr_state == RLS_PWR_ACTIVE) && (pwr_prev_r != RLS_PWR_ACTIVE);
    assign enter_off = (i_pwr_state == RLS_PWR_OFF) && (pwr_prev_r != RLS_PWR_OFF);
    assign up_slot_hit = (i_pwr_state == RLS_PWR_UP) && i_slot_strobe
        && (sw_r.switch_startup_slot == i_slot)
        && (sw_r.switch_startup_slot != RLS_SLOT_NONE)
        && (sw_r.switch_startup_slot != RLS_SLOT_LAST);
    assign down_slot_hit = (i_pwr_state == RLS_PWR_DOWN) && i_slot_strobe
        && (sw_r.switch_shutdown_slot == i_slot)
        && (sw_r.switch_shutdown_slot != RLS_SLOT_NONE)
        && (sw_r.switch_shutdown_slot != RLS_SLOT_LAST);
    assign fault_swoff = i_limit_det && (sw_r.switch_fault_action == RLS_ACT_SWOFF);

    //--------------------------------------------------------------------------
    // switch and output control
    //--------------------------------------------------------------------------
    always_comb begin
        seq_on_nxt = seq_on_r;
        if (up_slot_hit) begin
            seq_on_nxt = 1'b1;
        end
        if (enter_active && (sw_r.switch_startup_slot == RLS_SLOT_LAST)) begin
            seq_on_nxt = 1'b1;
        end
        if (down_slot_hit || enter_off) begin
            seq_on_nxt = 1'b0;
        end
        if (fault_swoff) begin
            seq_on_nxt = 1'b0;
        end
        sysoff_nxt = i_limit_det && sw_r.switch_fault_action[1];
        sw_out_nxt = seq_on_nxt
            && ((i_pwr_state != RLS_PWR_HIB) || sw_r.switch_hibernate_keep);
        bulk_nxt = !sw_out_nxt
            && (((i_pwr_state == RLS_PWR_ACTIVE) && sw_r.active_bulk_detect_en)
            || ((i_pwr_state == RLS_PWR_HIB) && sw_r.hibernate_bulk_detect_en));
        dis_nxt = !i_reg1_en
            && (!rg1_r.reg1_output_float || i_other_regs_off);
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            seq_on_r <= 1'b0;
            sw_out_r <= 1'b0;
            bulk_r <= 1'b0;
            sysoff_r <= 1'b0;
            dis_r <= 1'b0;
            pwr_prev_r <= RLS_PWR_OFF;
        end else begin
            seq_on_r <= seq_on_nxt;
            sw_out_r <= sw_out_nxt;
            bulk_r <= bulk_nxt;
            sysoff_r <= sysoff_nxt;
            dis_r <= dis_nxt;
            pwr_prev_r <= i_pwr_state;
        end
    end

    //--------------------------------------------------------------------------
    // register file
    //--------------------------------------------------------------------------
    always_comb begin
        ev = '0;
        ev[RLS_IRQ_LIMIT] = i_limit_det;
        ev[RLS_IRQ_SYSOFF] = sysoff_nxt;
        ev[RLS_IRQ_SWOFF] = fault_swoff;
        sw_nxt = sw_r;
        rg1_nxt = rg1_r;
        stat_nxt = stat_r;
        mask_nxt = mask_r;
        if (i_bus.wr) begin
            unique case (i_bus.addr)
                RLS_ADDR_SW: begin
                    sw_nxt = rls_sw_ctl_s'(i_bus.wdata & RLS_SW_WMASK);
                end
                RLS_ADDR_RG1: begin
                    rg1_nxt = rls_rg1_ctl_s'(i_bus.wdata & RLS_RG1_WMASK);
                end
                RLS_ADDR_IRQ_STAT: begin
                    stat_nxt = stat_r & ~i_bus.wdata[RLS_IRQ_W-1:0];
                end
                RLS_ADDR_IRQ_MASK: begin
                    mask_nxt = i_bus.wdata[RLS_IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
        if (i_sm_reload) begin
            sw_nxt = rls_sw_ctl_s'((sw_nxt & ~RLS_SW_SMMASK) | (RLS_SW_DEF & RLS_SW_SMMASK));
            rg1_nxt = rls_rg1_ctl_s'((rg1_nxt & ~RLS_RG1_SMMASK)
                | (RLS_RG1_DEF & RLS_RG1_SMMASK));
        end
        stat_nxt = stat_nxt | ev;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            sw_r <= rls_sw_ctl_s'(RLS_SW_DEF);
            rg1_r <= rls_rg1_ctl_s'(RLS_RG1_DEF);
            stat_r <= '0;
            mask_r <= '0;
        end else begin
            sw_r <= sw_nxt;
            rg1_r <= rg1_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
        end
    end

    //--------------------------------------------------------------------------
    // read port
    //--------------------------------------------------------------------------
    always_comb begin
        rd_nxt = 16'h0000;
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                RLS_ADDR_SW: rd_nxt = sw_r;
                RLS_ADDR_RG1: rd_nxt = rg1_r;
                RLS_ADDR_IRQ_STAT: rd_nxt = 16'(stat_r);
                RLS_ADDR_IRQ_MASK: rd_nxt = 16'(mask_r);
                RLS_ADDR_STATUS: rd_nxt = {12'h000, dis_r, sysoff_r, bulk_r, sw_out_r};
                default: rd_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rd_r <= 16'h0000;
        end else begin
            rd_r <= rd_nxt;
        end
    end

    //--------------------------------------------------------------------------
    // voltage decode
    //--------------------------------------------------------------------------
    rls_vdecode u_vdecode (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_code(rg1_r.reg1_voltage_code),
        .i_switch_mode(rg1_r.reg1_switch_mode),
        .o_mv(o_reg1_mv)
    );

    //--------------------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------------------
    assign o_rd_data = rd_r;
    assign o_switch_on = sw_out_r;
    assign o_bulk_detect_en = bulk_r;
    assign o_sys_shutdown = sysoff_r;
    assign o_reg1_switch_mode = rg1_r.reg1_switch_mode;
    assign o_reg1_voltage_code = rg1_r.reg1_voltage_code;
    assign o_reg1_discharge = dis_r;
    assign o_irq = |(stat_r & mask_r);

    //--------------------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    property p_fault_swoff;
        fault_swoff |=> !o_switch_on;
    endproperty
    a_fault_swoff: assert property (p_fault_swoff) else $error("switch on after fault");

    property p_fault_sysoff;
        i_limit_det && sw_r.switch_fault_action[1] |=> o_sys_shutdown
            ##1 (!o_sys_shutdown || $past(i_limit_det));
    endproperty
    a_fault_sysoff: assert property (p_fault_sysoff) else $error("no system shutdown");

    property p_fault_ignore;
        !(i_limit_det && sw_r.switch_fault_action[1]) |=> !o_sys_shutdown;
    endproperty
    a_fault_ignore: assert property (p_fault_ignore) else $error("spurious shutdown");

    property p_up_slot;
        up_slot_hit && !i_limit_det |=> o_switch_on;
    endproperty
    a_up_slot: assert property (p_up_slot) else $error("switch not on at slot");

    property p_enter_active;
        enter_active && (sw_r.switch_startup_slot == RLS_SLOT_LAST) && !fault_swoff
            |=> o_switch_on;
    endproperty
    a_enter_active: assert property (p_enter_active) else $error("switch not on at active");

    property p_enter_off;
        enter_off |=> !o_switch_on;
    endproperty
    a_enter_off: assert property (p_enter_off) else $error("switch on in off");

    property p_hib_off;
        (i_pwr_state == RLS_PWR_HIB) && !sw_r.switch_hibernate_keep |=> !o_switch_on;
    endproperty
    a_hib_off: assert property (p_hib_off) else $error("switch on in hibernate");

    property p_hib_bulk;
        (i_pwr_state == RLS_PWR_HIB) && !sw_r.hibernate_bulk_detect_en |=> !o_bulk_detect_en;
    endproperty
    a_hib_bulk: assert property (p_hib_bulk) else $error("hibernate bulk detect on");

    property p_act_bulk;
        (i_pwr_state == RLS_PWR_ACTIVE) && sw_r.active_bulk_detect_en && !seq_on_nxt
            |=> o_bulk_detect_en && !o_switch_on;
    endproperty
    a_act_bulk: assert property (p_act_bulk) else $error("active bulk detect off");

    property p_reload;
        i_sm_reload |=> ((sw_r & RLS_SW_SMMASK) == (RLS_SW_DEF & RLS_SW_SMMASK))
            && ((rg1_r & RLS_RG1_SMMASK) == (RLS_RG1_DEF & RLS_RG1_SMMASK));
    endproperty
    a_reload: assert property (p_reload) else $error("defaults not reloaded");

    property p_swmode;
        o_reg1_switch_mode |=> o_reg1_mv == RLS_MV_NONE;
    endproperty
    a_swmode: assert property (p_swmode) else $error("voltage used in switch mode");

    property p_discharge;
        !i_reg1_en && (!rg1_r.reg1_output_float || i_other_regs_off) |=> o_reg1_discharge;
    endproperty
    a_discharge: assert property (p_discharge) else $error("output not discharged");

    property p_float;
        i_reg1_en || (rg1_r.reg1_output_float && !i_other_regs_off) |=> !o_reg1_discharge;
    endproperty
    a_float: assert property (p_float) else $error("output discharged wrongly");

    property p_vcode;
        !o_reg1_switch_mode && (o_reg1_voltage_code == 5'h10) |=> o_reg1_mv == 12'h708;
    endproperty
    a_vcode: assert property (p_vcode) else $error("wrong 1.8V decode");

    property p_rsv;
        i_bus.rd && (i_bus.addr == RLS_ADDR_RG1) |=> o_rd_data[15] == 1'b0
            && o_rd_data[13:11] == 3'h0 && o_rd_data[9:5] == 5'h00;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits nonzero");

    c_sysoff: cover property (i_limit_det && sw_r.switch_fault_action[1] ##1 o_sys_shutdown);
    c_swon: cover property (!o_switch_on ##1 o_switch_on);
    c_reload: cover property (i_sm_reload);
    c_irq: cover property (!o_irq ##1 o_irq);
endmodule

// ### logic/rls_pkg.sv
// package: register map, field layouts, defaults and types of the switch/regulator 1 control
//------------------------------------------------------------------------------
// Notes on behaviour
// - fault action: ignore, switch off, system off
// - start-up slot: never, slot 1-14, active
// - shutdown slot: slot 1-14, else on entering off
// - hibernate: switch off unless keep bit set
// - hibernate bulk detection enable, default one
// - active bulk detection enable, default one
// - state machine reload restores marked field defaults
// - switch mode ignores the voltage code
// - disabled regulator output discharged unless floating
// - all regulators off forces discharge
// - code to voltage: 50mV then 100mV steps
//------------------------------------------------------------------------------
package rls_pkg;

    //--------------------------------------------------------------------------
    // register offsets
    //--------------------------------------------------------------------------
    localparam logic [7:0] RLS_ADDR_SW = 8'hc7;
    localparam logic [7:0] RLS_ADDR_RG1 = 8'hc8;
    localparam logic [7:0] RLS_ADDR_IRQ_STAT = 8'hd0;
    localparam logic [7:0] RLS_ADDR_IRQ_MASK = 8'hd1;
    localparam logic [7:0] RLS_ADDR_STATUS = 8'hd2;

    //--------------------------------------------------------------------------
    // defaults and masks
    //--------------------------------------------------------------------------
    localparam logic [15:0] RLS_SW_DEF = 16'h0003;
    localparam logic [15:0] RLS_SW_WMASK = 16'hffd3;
    localparam logic [15:0] RLS_SW_SMMASK = 16'hfc00;
    localparam logic [15:0] RLS_RG1_DEF = 16'h001c;
    localparam logic [15:0] RLS_RG1_WMASK = 16'h441f;
    localparam logic [15:0] RLS_RG1_SMMASK = 16'h401f;

    //--------------------------------------------------------------------------
    // field codes
    //--------------------------------------------------------------------------
    localparam logic [1:0] RLS_ACT_IGNORE = 2'h0;
    localparam logic [1:0] RLS_ACT_SWOFF = 2'h1;
    localparam logic [3:0] RLS_SLOT_NONE = 4'h0;
    localparam logic [3:0] RLS_SLOT_LAST = 4'hf;
    localparam logic [11:0] RLS_MV_LO_BASE = 12'h384;
    localparam logic [11:0] RLS_MV_LO_STEP = 12'h032;
    localparam logic [11:0] RLS_MV_HI_BASE = 12'h708;
    localparam logic [11:0] RLS_MV_HI_STEP = 12'h064;
    localparam logic [11:0] RLS_MV_NONE = 12'h000;

    //--------------------------------------------------------------------------
    // interrupt bits
    //--------------------------------------------------------------------------
    localparam int RLS_IRQ_W = 3;
    localparam int RLS_IRQ_LIMIT = 0;
    localparam int RLS_IRQ_SYSOFF = 1;
    localparam int RLS_IRQ_SWOFF = 2;

    //--------------------------------------------------------------------------
    // types
    //--------------------------------------------------------------------------
    typedef enum logic [2:0] {
        RLS_PWR_OFF,
        RLS_PWR_UP,
        RLS_PWR_ACTIVE,
        RLS_PWR_HIB,
        RLS_PWR_DOWN
    } rls_pwr_e;

    typedef struct packed {
        logic [1:0] switch_fault_action;
        logic [3:0] switch_startup_slot;
        logic [3:0] switch_shutdown_slot;
        logic rsv5;
        logic switch_hibernate_keep;
        logic [1:0] rsv3;
        logic hibernate_bulk_detect_en;
        logic active_bulk_detect_en;
    } rls_sw_ctl_s;

    typedef struct packed {
        logic rsv15;
        logic reg1_switch_mode;
        logic [2:0] rsv13;
        logic reg1_output_float;
        logic [4:0] rsv9;
        logic [4:0] reg1_voltage_code;
    } rls_rg1_ctl_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } rls_bus_s;

endpackage

// ### logic/rls_vdecode.sv
// voltage code to millivolt decoder for regulator 1
`timescale 1ns/1ps
module rls_vdecode
    import rls_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [4:0] i_code,
    input wire logic i_switch_mode,
    output logic [11:0] o_mv
);
    logic [11:0] mv_r;
    logic [11:0] mv_nxt;

    //--------------------------------------------------------------------------
    // decode
    //--------------------------------------------------------------------------
    always_comb begin
        if (i_switch_mode) begin
            mv_nxt = RLS_MV_NONE;
        end else if (i_code[4]) begin
            mv_nxt = 12'(RLS_MV_HI_BASE + RLS_MV_HI_STEP * {8'h00, i_code[3:0]});
        end else begin
            mv_nxt = 12'(RLS_MV_LO_BASE + RLS_MV_LO_STEP * {8'h00, i_code[3:0]});
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            mv_r <= RLS_MV_NONE;
        end else begin
            mv_r <= mv_nxt;
        end
    end

    assign o_mv = mv_r;
endmodule

// ### testbench/rls_ctl_test.sv
// self-checking testbench for the switch and regulator 1 control block
`timescale 1ns/1ps
module rls_ctl_test
    import rls_pkg::*;
;
    //--------------------------------------------------------------------------
    // signals
    //--------------------------------------------------------------------------
    logic clk, rst_n, reload, strobe, limit, reg1_en, others_off;
    rls_bus_s bus;
    rls_pwr_e pwr;
    logic [3:0] slot;
    logic [15:0] rd_data;
    logic sw_on, bulk, sys_sd, sw_mode, dis, irq;
    logic [4:0] vcode;
    logic [11:0] mv;
    int num_errors;
    int check_count;
    logic [15:0] w;

    rls_ctl uut (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_bus(bus), .o_rd_data(rd_data),
        .i_sm_reload(reload), .i_pwr_state(pwr), .i_slot_strobe(strobe), .i_slot(slot),
        .i_limit_det(limit), .i_reg1_en(reg1_en), .i_other_regs_off(others_off),
        .o_switch_on(sw_on), .o_bulk_detect_en(bulk), .o_sys_shutdown(sys_sd),
        .o_reg1_switch_mode(sw_mode), .o_reg1_voltage_code(vcode), .o_reg1_mv(mv),
        .o_reg1_discharge(dis), .o_irq(irq)
    );

    //--------------------------------------------------------------------------
    // tasks
    //--------------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        chk(rd_data, exp);
    endtask

    task automatic set_pwr(input rls_pwr_e st);
        @(posedge clk);
        pwr <= st;
        tick(2);
    endtask

    task automatic slot_pulse(input logic [3:0] s);
        @(posedge clk);
        strobe <= 1'b1;
        slot <= s;
        @(posedge clk);
        strobe <= 1'b0;
        #1;
    endtask

    task automatic limit_pulse();
        @(posedge clk);
        limit <= 1'b1;
        @(posedge clk);
        limit <= 1'b0;
        #1;
    endtask

    function automatic logic [15:0] swc(input logic [1:0] act, input logic [3:0] st,
                                        input logic [3:0] sd, input logic [2:0] kbits);
        return {act, st, sd, 1'b0, kbits[2], 2'h0, kbits[1:0]};
    endfunction

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    //--------------------------------------------------------------------------
    // clock and watchdog
    //--------------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        #200000;
        num_errors++;
        $display("[FAIL] %0t: run timed out", $time);
        give_verdict();
    end

    //--------------------------------------------------------------------------
    // main sequence
    //--------------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        reload = 1'b0;
        strobe = 1'b0;
        limit = 1'b0;
        reg1_en = 1'b1;
        others_off = 1'b0;
        bus = '0;
        pwr = RLS_PWR_OFF;
        slot = 4'h0;
        num_errors = 0;
        check_count = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        tick(1);
        // defaults and map
        rd_chk(RLS_ADDR_SW, 16'h0003);
        rd_chk(RLS_ADDR_RG1, 16'h001c);
        rd_chk(RLS_ADDR_IRQ_STAT, 16'h0000);
        chk({4'h0, mv}, 16'h0bb8);
        wr(8'hc9, 16'hffff);
        rd_chk(8'hc9, 16'h0000);
        wr(RLS_ADDR_SW, 16'hffff);
        rd_chk(RLS_ADDR_SW, 16'hffd3);
        wr(RLS_ADDR_RG1, 16'hffff);
        rd_chk(RLS_ADDR_RG1, 16'h441f);
        $display("test registers done");
        // state machine reload of marked fields
        wr(RLS_ADDR_SW, 16'hffd0);
        wr(RLS_ADDR_RG1, 16'h4403);
        @(posedge clk);
        reload <= 1'b1;
        @(posedge clk);
        reload <= 1'b0;
        rd_chk(RLS_ADDR_SW, 16'h03d0);
        rd_chk(RLS_ADDR_RG1, 16'h041c);
        $display("test reload done");
        // voltage code table and switch mode
        for (int c = 0; c < 32; c++) begin
            wr(RLS_ADDR_RG1, 16'(c));
            tick(1);
            w = (c < 16) ? 16'(900 + 50 * c) : 16'(1800 + 100 * (c - 16));
            chk({4'h0, mv}, w);
            chk({11'h0, vcode}, 16'(c));
        end
        wr(RLS_ADDR_RG1, 16'h401c);
        tick(1);
        chk({4'h0, mv}, 16'h0000);
        chk({15'h0, sw_mode}, 16'h0001);
        $display("test voltage done");
        // discharge control
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            reg1_en <= i[2];
            others_off <= i[0];
            wr(RLS_ADDR_RG1, {5'h0, i[1], 10'h01c});
            tick(2);
            chk({15'h0, dis}, {15'h0, !i[2] && (!i[1] || i[0])});
        end
        $display("test discharge done");
        // start-up, hibernate, bulk detection
        wr(RLS_ADDR_SW, swc(2'h0, 4'h3, 4'h5, 3'h3));
        set_pwr(RLS_PWR_UP);
        slot_pulse(4'h2);
        chk({15'h0, sw_on}, 16'h0000);
        slot_pulse(4'h3);
        chk({15'h0, sw_on}, 16'h0001);
        set_pwr(RLS_PWR_ACTIVE);
        chk({14'h0, sw_on, bulk}, 16'h0002);
        set_pwr(RLS_PWR_HIB);
        chk({14'h0, sw_on, bulk}, 16'h0001);
        set_pwr(RLS_PWR_ACTIVE);
        chk({15'h0, sw_on}, 16'h0001);
        wr(RLS_ADDR_SW, swc(2'h0, 4'h3, 4'h5, 3'h7));
        set_pwr(RLS_PWR_HIB);
        chk({15'h0, sw_on}, 16'h0001);
        set_pwr(RLS_PWR_ACTIVE);
        $display("test start-up done");
        // fault actions and interrupt
        wr(RLS_ADDR_IRQ_MASK, 16'h0007);
        rd_chk(RLS_ADDR_IRQ_MASK, 16'h0007);
        limit_pulse();
        chk({14'h0, sys_sd, sw_on}, 16'h0001);
        tick(1);
        chk({15'h0, irq}, 16'h0001);
        rd_chk(RLS_ADDR_IRQ_STAT, 16'h0001);
        wr(RLS_ADDR_IRQ_STAT, 16'h0001);
        tick(1);
        chk({15'h0, irq}, 16'h0000);
        wr(RLS_ADDR_SW, swc(2'h1, 4'h3, 4'h5, 3'h7));
        limit_pulse();
        tick(1);
        chk({13'h0, sys_sd, sw_on, bulk}, 16'h0001);
        rd_chk(RLS_ADDR_STATUS, 16'h0002);
        rd_chk(RLS_ADDR_IRQ_STAT, 16'h0005);
        wr(RLS_ADDR_SW, swc(2'h1, 4'h3, 4'h5, 3'h6));
        tick(2);
        chk({15'h0, bulk}, 16'h0000);
        wr(RLS_ADDR_IRQ_STAT, 16'h0007);
        wr(RLS_ADDR_IRQ_MASK, 16'h0000);
        for (int a = 2; a < 4; a++) begin
            wr(RLS_ADDR_SW, swc(2'(a), 4'h3, 4'h5, 3'h7));
            limit_pulse();
            chk({15'h0, sys_sd}, 16'h0001);
            tick(1);
            chk({14'h0, sys_sd, irq}, 16'h0000);
            rd_chk(RLS_ADDR_IRQ_STAT, 16'h0003);
            wr(RLS_ADDR_IRQ_STAT, 16'h0003);
        end
        $display("test fault done");
        // shutdown slots and on-entry codes
        wr(RLS_ADDR_SW, swc(2'h0, 4'h3, 4'h5, 3'h3));
        set_pwr(RLS_PWR_UP);
        slot_pulse(4'h3);
        set_pwr(RLS_PWR_DOWN);
        slot_pulse(4'h4);
        chk({15'h0, sw_on}, 16'h0001);
        slot_pulse(4'h5);
        chk({15'h0, sw_on}, 16'h0000);
        slot_pulse(4'h3);
        chk({15'h0, sw_on}, 16'h0000);
        wr(RLS_ADDR_SW, swc(2'h0, 4'hf, 4'hf, 3'h3));
        set_pwr(RLS_PWR_ACTIVE);
        chk({15'h0, sw_on}, 16'h0001);
        set_pwr(RLS_PWR_DOWN);
        slot_pulse(4'h5);
        chk({15'h0, sw_on}, 16'h0001);
        set_pwr(RLS_PWR_OFF);
        chk({15'h0, sw_on}, 16'h0000);
        wr(RLS_ADDR_SW, swc(2'h0, 4'h0, 4'h0, 3'h3));
        set_pwr(RLS_PWR_UP);
        slot_pulse(4'h1);
        set_pwr(RLS_PWR_ACTIVE);
        chk({15'h0, sw_on}, 16'h0000);
        $display("test shutdown done");
        give_verdict();
    end
endmodule
